/* File: src/cps_consts.svh */
// constants for the parallel host port front end
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

`define CPS_ADDR_W      8
`define CPS_BYTE_W      8
`define CPS_DATA_W      16
`define CPS_SERIAL_N    16
`define CPS_PIN_W       30
`define CPS_CLK_NS      25
`define CPS_RST_MIN_NS  100
`define CPS_RST_MIN_CYC ((`CPS_RST_MIN_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
`define CPS_IDLE_ACK    1'b1
`define CPS_DATA_ZERO   16'h0000
`define CPS_ADDR_ZERO   8'h00
// synchroniser reset pattern: select (top bit) comes out of reset inactive
`define CPS_PIN_RST     30'h20000000

`endif

/* File: src/cps_pkg.sv */
// types for the parallel host port front end
package cps_pkg;

	typedef enum logic [1:0] {
		MODE_NONMUX_DS,
		MODE_MUX_DS,
		MODE_MUX_RDWR
	} cps_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD_REQ,
		ST_RD_CAP,
		ST_ACK,
		ST_RELEASE
	} cps_state_t;

endpackage

/* File: src/cps_pin_sync.sv */
// two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module cps_pin_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstN,
	// pins in, synchronised copy out
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinSync
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rstN) begin
		// reset value must match the idle level, else a false access follows
		if (!rstN) begin
			meta_q <= RST;
			sync_q <= RST;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end

	assign pinSync = sync_q;

endmodule // cps_pin_sync

`default_nettype wire

/* File: src/cps_host_port.sv */
// parallel host port front end: strobes, address, data pins, ack, reset
//
// How it works
// - non-multiplexed mode takes the memory address from the cpu_addr lines
// - muxed strobe mode: strobe_or_read high is the data strobe, with select
// - non-muxed mode: strobe_or_read low is the data strobe, with select
// - read/write-strobe mode: strobe_or_read low is read, data lines driven
// - reset clears state and floats serial outputs and port data outputs
// - bus_mode_select high picks multiplexed, low picks non-multiplexed
// - port_select low activates the port; strobes ignored while high
// - direction_or_write gives direction, or is the active-low write strobe
// - transfer_ack marks completion, driven high at cycle end, then floated
`include "cps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cps_host_port (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// host pins
	input  wire logic                      portSelectN,
	input  wire logic                      strobe_or_read,
	input  wire logic                      directionOrWrite,
	input  wire logic                      bus_mode_select,
	input  wire logic                      rdwrStyleSelect,
	input  wire logic                      addrLatch,
	input  wire logic [`CPS_ADDR_W-1:0]    cpu_addr,
	// data pins, low byte doubles as address in muxed mode
	input  wire logic [`CPS_BYTE_W-1:0]    muxedAddrDataLowIn,
	output logic      [`CPS_BYTE_W-1:0]    muxedAddrDataLowOut,
	output logic                           muxedAddrDataLowOe,
	input  wire logic [`CPS_BYTE_W-1:0]    dataHighByteIn,
	output logic      [`CPS_BYTE_W-1:0]    dataHighByteOut,
	output logic                           dataHighByteOe,
	// acknowledge pin
	output logic                           transferAckOut,
	output logic                           transferAckOe,
	// serial stream drive enables from the core
	input  wire logic [`CPS_SERIAL_N-1:0]  serialOutEnReq,
	output logic      [`CPS_SERIAL_N-1:0]  serialOutOe,
	// internal memory side
	output logic      [`CPS_ADDR_W-1:0]    memAddr,
	output logic                           memRead,
	output logic                           memWrite,
	output logic      [`CPS_DATA_W-1:0]    memWrData,
	input  wire logic [`CPS_DATA_W-1:0]    memRdData,
	output logic                           coreRstN
);

	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisation

	logic rstMeta_q, rstSync_q;

	// async assert, two-flop release; outputs float at once on assert
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	assign coreRstN = rstSync_q;

	logic [`CPS_PIN_W-1:0]  pinRaw;
	logic [`CPS_PIN_W-1:0]  pinSync;
	logic                   selN, strobe, dirWr, modeSel, styleSel, latchIn;
	logic [`CPS_ADDR_W-1:0] addrIn;
	logic [`CPS_BYTE_W-1:0] lowIn;
	logic [`CPS_BYTE_W-1:0] highIn;

	assign pinRaw = {portSelectN, strobe_or_read, directionOrWrite,
		bus_mode_select, rdwrStyleSelect, addrLatch, cpu_addr,
		muxedAddrDataLowIn, dataHighByteIn};

	cps_pin_sync #(.W(`CPS_PIN_W), .RST(`CPS_PIN_RST)) u_sync (
		.clk     (clk),
		.rstN    (rstSync_q),
		.pinIn   (pinRaw),
		.pinSync (pinSync)
	);

	assign {selN, strobe, dirWr, modeSel, styleSel, latchIn, addrIn,
		lowIn, highIn} = pinSync;

	////////////////////////////////////////////////////////////////////////
	// mode and strobe decoding

	function automatic cps_pkg::cps_mode_t modeOf(input logic muxed,
		input logic style);
		if (!muxed)
			return cps_pkg::MODE_NONMUX_DS;
		else if (style)
			return cps_pkg::MODE_MUX_RDWR;
		else
			return cps_pkg::MODE_MUX_DS;
	endfunction

	// strobe in its active sense for the given mode
	function automatic logic strobeOn(input cps_pkg::cps_mode_t m,
		input logic s, input logic w);
		case (m)
			cps_pkg::MODE_MUX_DS:    return s;
			cps_pkg::MODE_NONMUX_DS: return !s;
			default:                 return !s || !w;
		endcase
	endfunction

	// read in ds modes comes from the direction level
	function automatic logic isRead(input cps_pkg::cps_mode_t m,
		input logic s, input logic w);
		return (m == cps_pkg::MODE_MUX_RDWR) ? !s : w;
	endfunction

	cps_pkg::cps_mode_t mode;
	logic               active;
	logic               readReq;
	assign mode    = modeOf(modeSel, styleSel);
	assign active  = !selN && strobeOn(mode, strobe, dirWr);
	assign readReq = isRead(mode, strobe, dirWr);

	////////////////////////////////////////////////////////////////////////
	// multiplexed address latch

	logic                   latchDly_q;
	logic [`CPS_ADDR_W-1:0] muxAddr_q;
	logic [`CPS_ADDR_W-1:0] muxAddr_d;

	// address is taken as the latch strobe falls
	always_comb begin
		muxAddr_d = (latchDly_q && !latchIn) ? lowIn : muxAddr_q;
	end

	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			latchDly_q <= 1'b0;
			muxAddr_q  <= `CPS_ADDR_ZERO;
		end else begin
			latchDly_q <= latchIn;
			muxAddr_q  <= muxAddr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// access sequencer

	cps_pkg::cps_state_t    state_q, state_d;
	logic [`CPS_ADDR_W-1:0] addr_q, addr_d;
	logic [`CPS_DATA_W-1:0] wrData_q, wrData_d;
	logic [`CPS_DATA_W-1:0] rdData_q, rdData_d;
	logic                   rd_q, rd_d;
	logic                   wr_q, wr_d;
	logic                   dataOe_q, dataOe_d;
	logic                   ackOut_q, ackOut_d;
	logic                   ackOe_q, ackOe_d;
	logic [`CPS_SERIAL_N-1:0] serOe_q;
	always_comb begin
		state_d  = state_q;
		addr_d   = addr_q;
		wrData_d = wrData_q;
		rdData_d = rdData_q;
		rd_d     = 1'b0;
		wr_d     = 1'b0;
		dataOe_d = dataOe_q;
		ackOut_d = ackOut_q;
		ackOe_d  = ackOe_q;
		case (state_q)
			cps_pkg::ST_IDLE: begin
				ackOe_d  = 1'b0;
				ackOut_d = `CPS_IDLE_ACK;
				dataOe_d = 1'b0;
				if (active) begin
					addr_d = (mode == cps_pkg::MODE_NONMUX_DS) ? addrIn
						: muxAddr_q;
					if (readReq) begin
						rd_d    = 1'b1;
						state_d = cps_pkg::ST_RD_REQ;
					end else begin
						wr_d     = 1'b1;
						wrData_d = {highIn, lowIn};
						ackOut_d = 1'b0;
						ackOe_d  = 1'b1;
						state_d  = cps_pkg::ST_ACK;
					end
				end
			end
			cps_pkg::ST_RD_REQ: state_d = cps_pkg::ST_RD_CAP;
			cps_pkg::ST_RD_CAP: begin
				rdData_d = memRdData;
				dataOe_d = 1'b1;
				state_d  = cps_pkg::ST_ACK;
			end
			cps_pkg::ST_ACK: begin
				ackOut_d = 1'b0;
				ackOe_d  = 1'b1;
				if (!active) begin
					ackOut_d = `CPS_IDLE_ACK;
					dataOe_d = 1'b0;
					state_d  = cps_pkg::ST_RELEASE;
				end
			end
			default: begin
				// one cycle of driven high speeds the pull-up
				ackOut_d = `CPS_IDLE_ACK;
				ackOe_d  = 1'b0;
				state_d  = cps_pkg::ST_IDLE;
			end
		endcase
	end

	// reset copy asserts asynchronously, so pins float at once
	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q  <= cps_pkg::ST_IDLE;
			addr_q   <= `CPS_ADDR_ZERO;
			wrData_q <= `CPS_DATA_ZERO;
			rdData_q <= `CPS_DATA_ZERO;
			rd_q     <= 1'b0;
			wr_q     <= 1'b0;
			dataOe_q <= 1'b0;
			ackOut_q <= `CPS_IDLE_ACK;
			ackOe_q  <= 1'b0;
			serOe_q  <= '0;
		end else begin
			state_q  <= state_d;
			addr_q   <= addr_d;
			wrData_q <= wrData_d;
			rdData_q <= rdData_d;
			rd_q     <= rd_d;
			wr_q     <= wr_d;
			dataOe_q <= dataOe_d;
			ackOut_q <= ackOut_d;
			ackOe_q  <= ackOe_d;
			serOe_q  <= serialOutEnReq;
		end
	end

	assign memAddr             = addr_q;
	assign memRead             = rd_q;
	assign memWrite            = wr_q;
	assign memWrData           = wrData_q;
	assign muxedAddrDataLowOut = rdData_q[`CPS_BYTE_W-1:0];
	assign dataHighByteOut     = rdData_q[`CPS_DATA_W-1:`CPS_BYTE_W];
	assign muxedAddrDataLowOe  = dataOe_q;
	assign dataHighByteOe      = dataOe_q;
	assign transferAckOut      = ackOut_q;
	assign transferAckOe       = ackOe_q;
	assign serialOutOe         = serOe_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_q);

	a_nonmux_addr_src: assert property (
		(state_q == cps_pkg::ST_IDLE && active
			&& mode == cps_pkg::MODE_NONMUX_DS) |=> memAddr == $past(addrIn))
		else $error("non-muxed address not taken from address lines");
	a_muxds_strobe_high: assert property (
		(state_q == cps_pkg::ST_IDLE && mode == cps_pkg::MODE_MUX_DS
			&& !selN && !strobe) |=> !memRead && !memWrite)
		else $error("muxed strobe low started an access");
	a_nonmux_strobe_low: assert property (
		(state_q == cps_pkg::ST_IDLE && mode == cps_pkg::MODE_NONMUX_DS
			&& !selN && strobe) |=> !memRead && !memWrite)
		else $error("non-muxed strobe high started an access");
	a_read_drives_data: assert property (
		(state_q == cps_pkg::ST_IDLE && active && readReq)
			|=> memRead ##2 muxedAddrDataLowOe && dataHighByteOe)
		else $error("read did not drive data lines in time");
	a_reset_floats_all: assert property ($rose(rstSync_q) |->
		!muxedAddrDataLowOe && !transferAckOe && serialOutOe == '0)
		else $error("outputs driven out of reset");
	a_ignore_unselected: assert property (
		(state_q == cps_pkg::ST_IDLE && selN) |=> !memRead && !memWrite)
		else $error("access taken while port not selected");
	a_write_no_drive: assert property (
		memWrite |-> !muxedAddrDataLowOe ##1 !muxedAddrDataLowOe)
		else $error("data lines driven during a write");
	a_ack_release_high: assert property (
		(transferAckOe && !transferAckOut && !active)
			|=> transferAckOe && transferAckOut ##1 !transferAckOe)
		else $error("ack not driven high then floated");
	// read data was captured two cycles before ack falls
	a_ack_after_data: assert property (
		$fell(transferAckOut) |-> memWrite
			|| (muxedAddrDataLowOe && $past(state_q, 2) == cps_pkg::ST_RD_CAP))
		else $error("ack low before data ready");
	a_ack_held_low: assert property (state_q == cps_pkg::ST_ACK
		&& active |=> !transferAckOut && transferAckOe)
		else $error("ack released while strobe held");

endmodule // cps_host_port

`default_nettype wire

/* File: tb/cps_host_model.sv */
// host processor model that drives the parallel port pins
`timescale 1ns/1ps
`default_nettype none

module cps_host_model (
	// clock
	input  wire logic        clk,
	// host-driven pins
	output logic             portSelectN,
	output logic             strobe_or_read,
	output logic             directionOrWrite,
	output logic             bus_mode_select,
	output logic             rdwrStyleSelect,
	output logic             addrLatch,
	output logic [7:0]       cpu_addr,
	// resolved data lines and device drive
	output logic [15:0]      dataLine,
	input  wire logic [15:0] devOut,
	input  wire logic [1:0]  devOe,
	input  wire logic        ackOut,
	input  wire logic        ackOe
);
	logic [15:0] hostVal;
	logic        hostOe;
	logic        ackLine;

	// pull-up on ack; floating data shows the inverse so a miss cannot match
	assign ackLine = ackOe ? ackOut : 1'b1;
	assign dataLine[7:0] = devOe[0] ? devOut[7:0]
		: (hostOe ? hostVal[7:0] : ~hostVal[7:0]);
	assign dataLine[15:8] = devOe[1] ? devOut[15:8]
		: (hostOe ? hostVal[15:8] : ~hostVal[15:8]);

	initial begin
		{portSelectN, strobe_or_read, directionOrWrite} = 3'h7;
		{bus_mode_select, rdwrStyleSelect, addrLatch, hostOe} = 4'h0;
		cpu_addr = 8'h00;
		hostVal = 16'h0000;
	end

	// mode 0 non-muxed strobe, 1 muxed strobe, 2 muxed read/write strobes
	task automatic access(input logic [1:0] mode, input logic rd,
		input logic [7:0] addr, input logic [15:0] wd,
		output logic [15:0] rdat, output bit ok);
		int n;
		bit sawHigh;
		ok = 1'b0;
		sawHigh = 1'b0;
		rdat = 16'h0000;
		@(posedge clk);
		#2;
		portSelectN = 1'b1;
		bus_mode_select = (mode != 2'h0);
		rdwrStyleSelect = (mode == 2'h2);
		strobe_or_read = (mode != 2'h1);
		directionOrWrite = 1'b1;
		cpu_addr = (mode == 2'h0) ? addr : ~addr;
		hostOe = 1'b1;
		hostVal = {~addr, addr};
		repeat (4) @(posedge clk);
		#2;
		if (mode != 2'h0) begin
			addrLatch = 1'b1;
			repeat (3) @(posedge clk);
			#2;
			addrLatch = 1'b0;
			repeat (3) @(posedge clk);
			#2;
		end
		hostOe = !rd;
		hostVal = rd ? hostVal : wd;
		portSelectN = 1'b0;
		directionOrWrite = rd;
		strobe_or_read = (mode == 2'h1) | ((mode == 2'h2) & !rd);
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge clk);
			if (ackLine == 1'b0) begin
				ok = 1'b1;
				rdat = dataLine;
			end
		end
		#2;
		strobe_or_read = (mode != 2'h1);
		directionOrWrite = 1'b1;
		portSelectN = 1'b1;
		hostOe = 1'b0;
		for (n = 0; n < 10 && ackOe; n++) begin
			@(posedge clk);
			sawHigh |= (ackOe && ackOut);
		end
		ok = ok & sawHigh & !ackOe;
	endtask
endmodule // cps_host_model

`default_nettype wire

/* File: tb/cps_host_port_tb.sv */
// self-checking bench for the parallel host port front end
`include "cps_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cps_host_port_tb;
	logic        clk, rst_n;
	logic        portSelectN, strobe_or_read, directionOrWrite;
	logic        bus_mode_select, rdwrStyleSelect, addrLatch;
	logic [7:0]  cpu_addr, lowOut, highOut, memAddr, wrA;
	logic        lowOe, highOe, transferAckOut, transferAckOe;
	logic [15:0] dataLine, serialOutEnReq, serialOutOe;
	logic [15:0] memWrData, memRdData, wrD;
	logic        memRead, memWrite, coreRstN;
	int          failures, tests_run, rdN, wrN;

	cps_host_port cps_host_port_i (.clk(clk), .rst_n(rst_n),
		.portSelectN(portSelectN), .strobe_or_read(strobe_or_read),
		.directionOrWrite(directionOrWrite),
		.bus_mode_select(bus_mode_select), .rdwrStyleSelect(rdwrStyleSelect),
		.addrLatch(addrLatch), .cpu_addr(cpu_addr),
		.muxedAddrDataLowIn(dataLine[7:0]), .muxedAddrDataLowOut(lowOut),
		.muxedAddrDataLowOe(lowOe), .dataHighByteIn(dataLine[15:8]),
		.dataHighByteOut(highOut), .dataHighByteOe(highOe),
		.transferAckOut(transferAckOut), .transferAckOe(transferAckOe),
		.serialOutEnReq(serialOutEnReq), .serialOutOe(serialOutOe),
		.memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
		.memWrData(memWrData), .memRdData(memRdData), .coreRstN(coreRstN));

	cps_host_model host_i (.clk(clk), .portSelectN(portSelectN),
		.strobe_or_read(strobe_or_read), .directionOrWrite(directionOrWrite),
		.bus_mode_select(bus_mode_select), .rdwrStyleSelect(rdwrStyleSelect),
		.addrLatch(addrLatch), .cpu_addr(cpu_addr), .dataLine(dataLine),
		.devOut({highOut, lowOut}), .devOe({highOe, lowOe}),
		.ackOut(transferAckOut), .ackOe(transferAckOe));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [15:0] rdFn(input logic [7:0] a);
		return {~a, a} ^ 16'h3C5A;
	endfunction

	// internal memory: answers one cycle after the read pulse
	always @(posedge clk) begin
		if (memRead === 1'b1) begin
			memRdData <= #2 rdFn(memAddr);
			rdN <= rdN + 1;
		end
		if (memWrite === 1'b1) begin
			wrN <= wrN + 1;
			wrA <= memAddr;
			wrD <= memWrData;
		end
	end

	task automatic cmpData(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpFlag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic runBatch(input int cnt);
		logic [1:0]  mode;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wd, rdat;
		bit          ok;
		int          r0, w0;
		for (int i = 0; i < cnt; i++) begin
			mode = 2'(i % 3);
			rd = (i < 6) ? 1'(i / 3) : 1'($urandom % 2);
			addr = (i < 6) ? {8{i[0]}} : 8'($urandom);
			wd = 16'($urandom);
			r0 = rdN;
			w0 = wrN;
			host_i.access(mode, rd, addr, wd, rdat, ok);
			cmpFlag(ok, 1'b1);
			if (!ok)
				finish_test();
			cmpData(16'(rdN - r0), {15'h0000, rd});
			cmpData(16'(wrN - w0), {15'h0000, !rd});
			if (rd)
				cmpData(rdat, rdFn(addr));
			else
				cmpData({wrA, wrD[15:8]}, {addr, wd[15:8]});
			if (!rd)
				cmpData({8'h00, wrD[7:0]}, {8'h00, wd[7:0]});
		end
	endtask

	initial begin
		{failures, tests_run, rdN, wrN} = '0;
		rst_n = 1'b0;
		serialOutEnReq = 16'h0000;
		memRdData = 16'h0000;
		void'($urandom(12));
		repeat (5) @(posedge clk);
		#2;
		rst_n = 1'b1;
		serialOutEnReq = 16'($urandom) | 16'h8001;
		repeat (4) @(posedge clk);
		runBatch(18);
		cmpData(serialOutOe, serialOutEnReq);
		#2;
		rst_n = 1'b0;
		#1;
		cmpData(serialOutOe, 16'h0000);
		cmpFlag(lowOe | highOe | transferAckOe | coreRstN, 1'b0);
		repeat (5) @(posedge clk);
		#2;
		rst_n = 1'b1;
		repeat (4) @(posedge clk);
		cmpFlag(coreRstN, 1'b1);
		runBatch(12);
		// strobes toggle with the port deselected
		{rdN, wrN} = '0;
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			#2;
			host_i.strobe_or_read = k[0];
			host_i.directionOrWrite = k[1];
		end
		repeat (6) @(posedge clk);
		cmpData(16'(rdN + wrN), 16'h0000);
		cmpFlag(transferAckOe | lowOe, 1'b0);
		finish_test();
	end
endmodule // cps_host_port_tb

`default_nettype wire
